// *** src/zqtc_top.sv ***
// Top of the calibration and on-die termination control block
`default_nettype none
module zqtc_top
  import zqtc_pkg::*;
#(
  parameter int ZQINIT_NCK = ZQTC_ZQINIT_NCK,
  parameter int ZQOPER_NCK = ZQTC_ZQOPER_NCK,
  parameter int ZQCS_NCK   = ZQTC_ZQCS_NCK,
  parameter int DLY_DEPTH  = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_zq_long,
  input  wire logic        cmd_zq_short,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic        cke,
  input  wire logic        odt_pin,
  input  wire logic        self_refresh,
  output logic      [1:0]  rtt_state,
  output logic      [2:0]  rtt_value,
  output logic      [7:0]  ron_code,
  output logic      [7:0]  rtt_code,
  output logic             zq_current_on,
  output logic             cal_busy,
  output logic             term_tdqs_en,
  output logic             term_upper_en,
  output logic             protocol_err
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] zqtc_sub(input logic [7:0] a, input logic [7:0] b);
    zqtc_sub = (a > b) ? a - b : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [31:0]          mode;
    logic [7:0]           target;
    logic [7:0]           cwl;
    logic [7:0]           al;
    logic [7:0]           pl;
    logic [7:0]           cl;
    logic [DLY_DEPTH-1:0] odt_hist;
    logic [DLY_DEPTH-1:0] rd_hist;
    logic [7:0]           wr_cnt;
    logic [7:0]           rd_cnt;
    logic                 err;
    logic [31:0]          rdata;
    logic [1:0]           rtt_st;
    logic [2:0]           rtt_val;
  } zqtc_top_t;
  zqtc_top_t s_reg, s_next;

  zqtc_cal_if cal ();
  zqtc_cal_engine #(
    .ZQINIT_NCK (ZQINIT_NCK),
    .ZQOPER_NCK (ZQOPER_NCK),
    .ZQCS_NCK   (ZQCS_NCK)
  ) u_eng (
    .pclk    (pclk),
    .presetn (presetn),
    .cal     (cal)
  );

  logic        wr_en;
  logic        rd_en;
  logic [7:0]  sub;
  logic [7:0]  dodtl;
  logic [7:0]  rodtl;
  logic [7:0]  rd_len;
  logic        odt_dly;
  logic        rd_dly;
  logic [2:0]  f_nom;
  logic [2:0]  f_wr;
  logic [2:0]  f_park;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign f_nom  = s_reg.mode[ZQTC_NOM_LSB +: 3];
  assign f_wr   = s_reg.mode[ZQTC_WR_LSB +: 3];
  assign f_park = s_reg.mode[ZQTC_PARK_LSB +: 3];
  assign sub    = s_reg.mode[ZQTC_PRE2_BIT] ? ZQTC_PRE2_SUB : ZQTC_PRE1_SUB;
  assign dodtl  = zqtc_sub(s_reg.cwl + s_reg.al + s_reg.pl, sub);
  assign rodtl  = zqtc_sub(s_reg.cl + s_reg.al + s_reg.pl, sub);
  assign rd_len = ZQTC_BL_HALF + sub + {7'h00, s_reg.mode[ZQTC_CRC_BIT]};
  assign odt_dly = (dodtl == 8'h00) ? odt_pin : s_reg.odt_hist[dodtl[5:0] - 6'd1];
  assign rd_dly  = (rodtl == 8'h00) ? cmd_read : s_reg.rd_hist[rodtl[5:0] - 6'd1];

  ////////////////////////////////////////////////////////////////////////////
  // Calibration start
  assign cal.start    = (cmd_zq_long || cmd_zq_short) && !cal.busy;
  assign cal.long_cal = cmd_zq_long;
  assign cal.target   = s_reg.target;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.odt_hist = {s_reg.odt_hist[DLY_DEPTH-2:0], odt_pin && !self_refresh};
    s_next.rd_hist  = {s_reg.rd_hist[DLY_DEPTH-2:0], cmd_read};
    // Write termination window: ODTLcnw..ODTLcwn8 collapsed to a burst hold
    if (cmd_write) begin
      s_next.wr_cnt = dodtl + 8'h08;
    end else if (s_reg.wr_cnt != 8'h00) begin
      s_next.wr_cnt = s_reg.wr_cnt - 8'h01;
    end
    if (rd_dly) begin
      s_next.rd_cnt = rd_len;
    end else if (s_reg.rd_cnt != 8'h00) begin
      s_next.rd_cnt = s_reg.rd_cnt - 8'h01;
    end
    // Controller misuse during a window; set wins over software clear
    if (wr_en && paddr == ZQTC_STATUS_OFS && pwdata[0]) begin
      s_next.err = 1'b0;
    end
    if (cal.busy && (cmd_write || cmd_read || !cke || odt_pin ||
        ((cmd_zq_long || cmd_zq_short) && !cal.start))) begin
      s_next.err = 1'b1;
    end
    // Termination resolution
    if (self_refresh) begin
      s_next.rtt_st  = ZQTC_RTT_OFF;
      s_next.rtt_val = 3'h0;
    end else if (s_reg.rd_cnt != 8'h00 || rd_dly ||
                 (f_nom == 3'h0 && f_wr == 3'h0 && f_park == 3'h0)) begin
      s_next.rtt_st  = ZQTC_RTT_OFF;
      s_next.rtt_val = 3'h0;
    end else if (f_wr != 3'h0 && s_reg.wr_cnt != 8'h00 && s_reg.wr_cnt <= 8'h08) begin
      s_next.rtt_st  = ZQTC_RTT_WR;
      s_next.rtt_val = f_wr;
    end else if (f_nom != 3'h0 && odt_dly && !cal.busy) begin
      s_next.rtt_st  = ZQTC_RTT_NOM;
      s_next.rtt_val = f_nom;
    end else if (f_park != 3'h0) begin
      s_next.rtt_st  = ZQTC_RTT_PARK;
      s_next.rtt_val = f_park;
    end else begin
      s_next.rtt_st  = ZQTC_RTT_OFF;
      s_next.rtt_val = 3'h0;
    end
    // Register writes
    if (wr_en) begin
      if (paddr == ZQTC_MODE_OFS) begin
        s_next.mode = pwdata;
      end else if (paddr == ZQTC_CODE_OFS) begin
        s_next.target = pwdata[7:0];
      end else if (paddr == ZQTC_LAT_OFS) begin
        s_next.cwl = pwdata[7:0];
        s_next.al  = pwdata[15:8];
        s_next.pl  = pwdata[23:16];
        s_next.cl  = pwdata[31:24];
      end
    end
    // Register reads
    s_next.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == ZQTC_CTRL_OFS) begin
        s_next.rdata = {29'h0, cal.init_done, cal.current_on, cal.busy};
      end else if (paddr == ZQTC_MODE_OFS) begin
        s_next.rdata = s_reg.mode;
      end else if (paddr == ZQTC_STATUS_OFS) begin
        s_next.rdata = {25'h0, s_reg.rtt_st, s_reg.rtt_val, 1'b0, s_reg.err};
      end else if (paddr == ZQTC_CODE_OFS) begin
        s_next.rdata = {16'h0, cal.code, s_reg.target};
      end else if (paddr == ZQTC_LAT_OFS) begin
        s_next.rdata = {s_reg.cl, s_reg.pl, s_reg.al, s_reg.cwl};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{mode: ZQTC_MODE_RST, target: ZQTC_CODE_RST, cwl: ZQTC_CWL_RST,
                 al: 8'h00, pl: 8'h00, cl: 8'h00, odt_hist: '0, rd_hist: '0,
                 wr_cnt: 8'h00, rd_cnt: 8'h00, err: 1'b0, rdata: 32'h0000_0000,
                 rtt_st: ZQTC_RTT_OFF, rtt_val: 3'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic addr_ok;
  assign addr_ok = (paddr == ZQTC_CTRL_OFS) || (paddr == ZQTC_MODE_OFS) ||
                   (paddr == ZQTC_STATUS_OFS) || (paddr == ZQTC_CODE_OFS) ||
                   (paddr == ZQTC_LAT_OFS);
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !addr_ok;
  assign prdata        = s_reg.rdata;
  assign rtt_state     = s_reg.rtt_st;
  assign rtt_value     = s_reg.rtt_val;
  assign ron_code      = cal.code;
  assign rtt_code      = cal.code;
  assign zq_current_on = cal.current_on;
  assign cal_busy      = cal.busy;
  assign term_tdqs_en  = s_reg.mode[ZQTC_TDQS_BIT] && !s_reg.mode[ZQTC_X16_BIT];
  assign term_upper_en = s_reg.mode[ZQTC_X16_BIT];
  assign protocol_err  = s_reg.err;
endmodule // zqtc_top
`default_nettype wire

// *** src/zqtc_pkg.sv ***
// Package of constants and types for the calibration and termination block
`default_nettype none
package zqtc_pkg;
  // APB register offsets
  localparam logic [7:0] ZQTC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ZQTC_MODE_OFS   = 8'h04;
  localparam logic [7:0] ZQTC_STATUS_OFS = 8'h08;
  localparam logic [7:0] ZQTC_CODE_OFS   = 8'h0c;
  localparam logic [7:0] ZQTC_LAT_OFS    = 8'h10;
  // Field positions in the mode register
  localparam int ZQTC_NOM_LSB  = 0;
  localparam int ZQTC_WR_LSB   = 3;
  localparam int ZQTC_PARK_LSB = 6;
  localparam int ZQTC_TDQS_BIT = 9;
  localparam int ZQTC_X16_BIT  = 10;
  localparam int ZQTC_PRE2_BIT = 11;
  localparam int ZQTC_CRC_BIT  = 12;
  // Reset values
  localparam logic [31:0] ZQTC_MODE_RST = 32'h0000_0000;
  localparam logic [7:0]  ZQTC_CODE_RST = 8'h80;
  localparam logic [7:0]  ZQTC_CWL_RST  = 8'h09;
  // Calibration windows in clock cycles
  localparam int ZQTC_ZQCS_NCK   = 128;
  localparam int ZQTC_ZQOPER_NCK = 512;
  localparam int ZQTC_ZQINIT_NCK = 1024;
  // Read termination-off latency offsets
  localparam logic [7:0] ZQTC_PRE1_SUB = 8'h02;
  localparam logic [7:0] ZQTC_PRE2_SUB = 8'h03;
  localparam logic [7:0] ZQTC_BL_HALF  = 8'h04;

  typedef enum logic [1:0] {ZQTC_RTT_OFF, ZQTC_RTT_WR, ZQTC_RTT_NOM, ZQTC_RTT_PARK} zqtc_rtt_t;
  typedef enum logic [1:0] {ZQTC_CAL_IDLE, ZQTC_CAL_RUN, ZQTC_CAL_XFER} zqtc_cal_t;
endpackage
`default_nettype wire

// *** src/zqtc_cal_if.sv ***
// Interface between the top and the calibration engine
`default_nettype none
interface zqtc_cal_if;
  logic       start;
  logic       long_cal;
  logic [7:0] target;
  logic       busy;
  logic       current_on;
  logic       done;
  logic [7:0] code;
  logic       init_done;
  modport top (output start, long_cal, target, input busy, current_on, done, code, init_done);
  modport eng (input start, long_cal, target, output busy, current_on, done, code, init_done);
endinterface
`default_nettype wire

// *** src/zqtc_cal_engine.sv ***
// Calibration engine: windowed code search and single-step transfer
`default_nettype none
module zqtc_cal_engine
  import zqtc_pkg::*;
#(
  parameter int ZQINIT_NCK = ZQTC_ZQINIT_NCK,
  parameter int ZQOPER_NCK = ZQTC_ZQOPER_NCK,
  parameter int ZQCS_NCK   = ZQTC_ZQCS_NCK
) (
  input  wire logic pclk,
  input  wire logic presetn,
  zqtc_cal_if.eng   cal
);
  typedef struct packed {
    zqtc_cal_t   st;
    logic [15:0] cnt;
    logic [7:0]  work;
    logic [7:0]  code;
    logic        init_done;
    logic        done;
  } zqtc_eng_t;
  zqtc_eng_t s_reg, s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      ZQTC_CAL_IDLE: begin
        if (cal.start) begin
          s_next.st   = ZQTC_CAL_RUN;
          s_next.work = s_reg.code;
          if (cal.long_cal && !s_reg.init_done) begin
            s_next.cnt = 16'(ZQINIT_NCK - 2);
          end else if (cal.long_cal) begin
            s_next.cnt = 16'(ZQOPER_NCK - 2);
          end else begin
            s_next.cnt = 16'(ZQCS_NCK - 2);
          end
          if (cal.long_cal) begin
            s_next.init_done = 1'b1;
          end
        end
      end
      ZQTC_CAL_RUN: begin
        // Step one unit per cycle toward target; a window of N cycles moves the code at most N-1 steps
        if (s_reg.work < cal.target) begin
          s_next.work = s_reg.work + 8'h01;
        end else if (s_reg.work > cal.target) begin
          s_next.work = s_reg.work - 8'h01;
        end
        if (s_reg.cnt == 16'h0000) begin
          s_next.st = ZQTC_CAL_XFER;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      default: begin
        s_next.code = s_reg.work;
        s_next.done = 1'b1;
        s_next.st   = ZQTC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: ZQTC_CAL_IDLE, cnt: 16'h0000, work: ZQTC_CODE_RST,
                 code: ZQTC_CODE_RST, init_done: 1'b0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cal.busy       = (s_reg.st != ZQTC_CAL_IDLE);
  assign cal.current_on = (s_reg.st == ZQTC_CAL_RUN);
  assign cal.done       = s_reg.done;
  assign cal.code       = s_reg.code;
  assign cal.init_done  = s_reg.init_done;
endmodule // zqtc_cal_engine
`default_nettype wire

// *** dv/zqtc_ctrl_model.sv ***
// Controller model: calibration commands, write and read pulses, termination lines
`default_nettype none
module zqtc_ctrl_model #(
  parameter int TXS_NCK = 4
) (
  input  wire logic pclk,
  input  wire logic cal_busy,
  output logic      cmd_zq_long,
  output logic      cmd_zq_short,
  output logic      cmd_write,
  output logic      cmd_read,
  output logic      cke,
  output logic      odt_pin,
  output logic      self_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_zq_long, cmd_zq_short, cmd_write, cmd_read, odt_pin, self_refresh} = '0;
    cke = 1'b1;
  end
  // Kind 0 long calibration, 1 short, 2 write, 3 read
  task automatic pulse(input int k);
    cmd_zq_long  <= k == 0;
    cmd_zq_short <= k == 1;
    cmd_write    <= k == 2;
    cmd_read     <= k == 3;
    @(posedge pclk);
    {cmd_zq_long, cmd_zq_short, cmd_write, cmd_read} <= '0;
  endtask
  // Banks idle, one device on the resistor; rude skips the quiet wait
  task automatic zq(input logic lng, input logic rude, output int n);
    n = 0;
    odt_pin <= 1'b0;
    pulse(lng ? 0 : 1);
    while (!rude && n < 2000) begin
      @(posedge pclk);
      if (cal_busy !== 1'b1) break;
      n++;
    end
  endtask
  // Self-refresh exit waits before any calibration command may follow
  task automatic lines(input logic odt, input logic sref);
    odt_pin      <= odt;
    self_refresh <= sref;
    cke          <= !sref;
    repeat (TXS_NCK) @(posedge pclk);
  endtask
endmodule  // zqtc_ctrl_model
`default_nettype wire

// *** dv/zqtc_properties.sv ***
// Checker of calibration windows, code transfer and termination choice
`default_nettype none
module zqtc_properties
  import zqtc_pkg::*;
#(
  parameter int ZQINIT_NCK = ZQTC_ZQINIT_NCK,
  parameter int ZQOPER_NCK = ZQTC_ZQOPER_NCK,
  parameter int ZQCS_NCK   = ZQTC_ZQCS_NCK
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        cmd_zq_long,
  input wire logic        cmd_zq_short,
  input wire logic        self_refresh,
  input wire logic [1:0]  rtt_state,
  input wire logic [2:0]  rtt_value,
  input wire logic [7:0]  ron_code,
  input wire logic [7:0]  rtt_code,
  input wire logic        zq_current_on,
  input wire logic        cal_busy,
  input wire logic        protocol_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        init_seen_reg;
  int          busy_cnt_reg;
  int          exp_len_reg;
  logic [31:0] mode_reg;
  logic        zq_take;
  logic [2:0]  field;
  assign zq_take = (cmd_zq_long || cmd_zq_short) && !cal_busy;
  assign field   = (rtt_state == 2'd1) ? mode_reg[5:3] :
                   (rtt_state == 2'd2) ? mode_reg[2:0] : mode_reg[8:6];
  // Window length expected from the kind of the accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_seen_reg <= 1'b0;
      busy_cnt_reg  <= 0;
      exp_len_reg   <= 0;
      mode_reg      <= ZQTC_MODE_RST;
    end else begin
      busy_cnt_reg <= cal_busy ? busy_cnt_reg + 1 : 0;
      if (zq_take) begin
        exp_len_reg   <= !cmd_zq_long ? ZQCS_NCK : init_seen_reg ? ZQOPER_NCK : ZQINIT_NCK;
        init_seen_reg <= init_seen_reg | cmd_zq_long;
      end
      if (psel && penable && pwrite && paddr == ZQTC_MODE_OFS) mode_reg <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_after_cmd: assert property (zq_take |=> cal_busy)
    else $error("calibration did not start");
  a_window_length: assert property (
    $fell(cal_busy) |-> busy_cnt_reg == exp_len_reg) else $error("window length wrong");
  a_codes_at_end: assert property (
    $changed(ron_code) |-> $changed(rtt_code) && $fell(cal_busy))
    else $error("codes updated apart or outside window end");
  a_current_off: assert property (($changed(ron_code) || !cal_busy) |-> !zq_current_on)
    else $error("calibration current left on");
  a_selfref_off: assert property (self_refresh |=> rtt_state == 2'd0)
    else $error("termination on in self refresh");
  a_rtt_value: assert property (
    rtt_state != 2'd0 && $stable(mode_reg) |-> rtt_value == field)
    else $error("termination value not from its field");
  a_no_nom_busy: assert property (cal_busy && $past(cal_busy) |-> rtt_state != 2'd2)
    else $error("nominal termination during calibration");
  a_err_overlap: assert property ((cmd_zq_long || cmd_zq_short) && cal_busy |=> protocol_err)
    else $error("overlapping command not flagged");
  c_long_taken: cover property (zq_take && cmd_zq_long);
  c_write_term: cover property (rtt_state == 2'd1);
  c_overlap: cover property ($rose(protocol_err));
endmodule  // zqtc_properties

bind zqtc_top zqtc_properties #(.ZQINIT_NCK(ZQINIT_NCK), .ZQOPER_NCK(ZQOPER_NCK),
  .ZQCS_NCK(ZQCS_NCK)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cmd_zq_long(cmd_zq_long), .cmd_zq_short(cmd_zq_short),
  .self_refresh(self_refresh), .rtt_state(rtt_state), .rtt_value(rtt_value),
  .ron_code(ron_code), .rtt_code(rtt_code), .zq_current_on(zq_current_on),
  .cal_busy(cal_busy), .protocol_err(protocol_err));
`default_nettype wire

// *** dv/tb.sv ***
// Bench: register access, calibration windows and termination choice
`default_nettype none
module tb
  import zqtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_N = 8, OPER_N = 6, CS_N = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_err;
  logic [7:0]  paddr, ron_code, rtt_code;
  logic [31:0] pwdata, prdata, rd;
  logic        cmd_zq_long, cmd_zq_short, cmd_write, cmd_read, cke, odt_pin, self_refresh;
  logic        zq_current_on, cal_busy, term_tdqs_en, term_upper_en, protocol_err;
  logic [1:0]  rtt_state;
  logic [2:0]  rtt_value;
  int          n_fail, cmp_count, n;

  zqtc_top #(.ZQINIT_NCK(INIT_N), .ZQOPER_NCK(OPER_N), .ZQCS_NCK(CS_N)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_zq_long(cmd_zq_long), .cmd_zq_short(cmd_zq_short), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cke(cke), .odt_pin(odt_pin), .self_refresh(self_refresh),
    .rtt_state(rtt_state), .rtt_value(rtt_value), .ron_code(ron_code), .rtt_code(rtt_code),
    .zq_current_on(zq_current_on), .cal_busy(cal_busy), .term_tdqs_en(term_tdqs_en),
    .term_upper_en(term_upper_en), .protocol_err(protocol_err));
  zqtc_ctrl_model i_ctl (
    .pclk(pclk), .cal_busy(cal_busy), .cmd_zq_long(cmd_zq_long), .cmd_zq_short(cmd_zq_short),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cke(cke), .odt_pin(odt_pin),
    .self_refresh(self_refresh));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  task automatic rtt_is(input logic [1:0] st, input logic [2:0] v);
    int k;
    k = 0;
    while (rtt_state !== st && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk({30'h0, rtt_state}, {30'h0, st});
    chk({29'h0, rtt_value}, {29'h0, v});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
  initial begin
    {n_fail, cmp_count} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ZQTC_CTRL_OFS, 32'h0);
    rdc(ZQTC_CODE_OFS, {16'h0, ZQTC_CODE_RST, ZQTC_CODE_RST});
    rdc(ZQTC_LAT_OFS, {24'h0, ZQTC_CWL_RST});
    rdc(8'h14, 32'h0);
    chk({31'h0, slv_err}, 32'h1);
    apb(1'b1, ZQTC_CODE_OFS, 32'h90);
    i_ctl.zq(1'b1, 1'b0, n);
    chk(n, INIT_N);
    apb(1'b1, ZQTC_CTRL_OFS, 32'hffff_ffff);
    rdc(ZQTC_CTRL_OFS, 32'h4);
    chk({31'h0, ron_code inside {[8'h81:8'h90]} && rtt_code === ron_code}, 32'h1);
    i_ctl.zq(1'b1, 1'b0, n);
    chk(n, OPER_N);
    i_ctl.zq(1'b0, 1'b0, n);
    chk(n, CS_N);
    i_ctl.zq(1'b0, 1'b1, n);
    @(posedge pclk);
    i_ctl.zq(1'b1, 1'b0, n);
    chk({31'h0, protocol_err}, 32'h1);
    apb(1'b1, ZQTC_STATUS_OFS, 32'h1);
    chk({31'h0, protocol_err}, 32'h0);
    // Short latencies: odt delay 2, read off after 4
    apb(1'b1, ZQTC_LAT_OFS, 32'h0600_0004);
    apb(1'b1, ZQTC_MODE_OFS, 32'h0000_00d1);
    rdc(ZQTC_MODE_OFS, 32'h0000_00d1);
    rtt_is(2'd3, 3'h3);
    rdc(ZQTC_STATUS_OFS, 32'h0000_006c);
    i_ctl.lines(1'b1, 1'b0);
    rtt_is(2'd2, 3'h1);
    i_ctl.pulse(2);
    rtt_is(2'd1, 3'h2);
    i_ctl.pulse(3);
    rtt_is(2'd0, 3'h0);
    i_ctl.lines(1'b0, 1'b1);
    chk({30'h0, rtt_state}, 32'h0);
    i_ctl.lines(1'b0, 1'b0);
    chk({31'h0, cal_busy}, 32'h0);
    apb(1'b1, ZQTC_MODE_OFS, 32'h0000_00d0);
    i_ctl.lines(1'b1, 1'b0);
    repeat (8) @(posedge pclk);
    chk({30'h0, rtt_state}, 32'h3);
    apb(1'b1, ZQTC_MODE_OFS, 32'h0000_0200);
    @(posedge pclk);
    chk({30'h0, term_upper_en, term_tdqs_en}, 32'h1);
    apb(1'b1, ZQTC_MODE_OFS, 32'h0000_0400);
    @(posedge pclk);
    chk({30'h0, term_upper_en, term_tdqs_en}, 32'h2);
    end_sim();
  end
endmodule  // tb
`default_nettype wire
